// ==== rtl/ccpr_top.sv ====
// capture/compare pair on a 16-bit up-counter, registers over apb
// assumes trigger pins synchronous to clk_sys_i, count clock = clk_sys_i
//
// Operation
// - register a compare match raises match_irq_a
// - register b compare match raises match_irq_b
// - a_trigger_source picks pin a or b
// - pin a source captures on opposite edge
// - pin b source captures on selected edge
// - register b captures on pin a edge
// - edge codes in prescaler bits 5:4, 7:6
// - capture select bits 0 and 2
// - zero compare matches after wrap only
// - compare below count waits for overflow
// - compare mode registers do not capture
// - capture wins over coinciding write
// - capture at stop is undefined
// - compare registers 16 bits, reset zero
// - count runs while mode bits 3:2 nonzero
// - mode register resets zero, byte writable
// - mode bits select stop, free, two clears
// - capture and interrupt on the same clock
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "ccpr_params.svh"

module ccpr_top (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // trigger pins
    input wire logic trig_in_a_i,
    input wire logic trig_in_b_i,
    // interrupt requests
    output logic match_irq_a_o,
    output logic match_irq_b_o
);
    function automatic logic addr_is(input logic [31:0] addr,
                                     input logic [15:0] idx);
        return addr == {14'h0000, idx, 2'b00};
    endfunction : addr_is

    // bus registers
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    // software registers
    logic [3:0] timer_mode_reg;
    logic [3:0] timer_mode_next;
    logic [2:0] cc_control_reg;
    logic [3:0] prescaler_mode_reg;
    // counter state
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic wrapped_reg;
    logic wrapped_next;
    logic irq_a_reg;
    logic irq_b_reg;

    ccpr_cc_if cc_a_if ();
    ccpr_cc_if cc_b_if ();

    ccpr_cc_reg u_cc_a (
        .clk_sys_i (clk_sys_i),
        .rst_n_i (rst_n_i),
        .cc (cc_a_if.unit)
    );

    ccpr_cc_reg u_cc_b (
        .clk_sys_i (clk_sys_i),
        .rst_n_i (rst_n_i),
        .cc (cc_b_if.unit)
    );

    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;

    ccpr_edge_det u_edge_a (
        .clk_sys_i (clk_sys_i),
        .rst_n_i (rst_n_i),
        .pin_i (trig_in_a_i),
        .rise_o (rise_a),
        .fall_o (fall_a)
    );

    // trig_in_b shares its pin with the timer output, which lives
    // outside this block; the pin owner keeps it an input here
    ccpr_edge_det u_edge_b (
        .clk_sys_i (clk_sys_i),
        .rst_n_i (rst_n_i),
        .pin_i (trig_in_b_i),
        .rise_o (rise_b),
        .fall_o (fall_b)
    );

    // address decode
    wire hit_count = addr_is(paddr_i, `CCPR_IDX_COUNT);
    wire hit_cc_a = addr_is(paddr_i, `CCPR_IDX_CC_A);
    wire hit_cc_b = addr_is(paddr_i, `CCPR_IDX_CC_B);
    wire hit_mode = addr_is(paddr_i, `CCPR_IDX_MODE);
    wire hit_ctrl = addr_is(paddr_i, `CCPR_IDX_CTRL);
    wire hit_presc = addr_is(paddr_i, `CCPR_IDX_PRESC);
    wire hit_any = hit_count | hit_cc_a | hit_cc_b | hit_mode |
                   hit_ctrl | hit_presc;
    wire setup = psel_i & ~penable_i;
    // writes land only at the completing access edge
    wire wr_fire = psel_i & penable_i & pwrite_i & pready_reg;

    // field decode
    wire [1:0] mode_sel = {timer_mode_reg[`CCPR_MODE_HI],
                           timer_mode_reg[`CCPR_MODE_MID]};
    wire a_cap_mode = cc_control_reg[`CCPR_CTRL_A_CAP];
    wire a_src_pin_a = cc_control_reg[`CCPR_CTRL_A_SRC];
    wire b_cap_mode = cc_control_reg[`CCPR_CTRL_B_CAP];
    wire [1:0] a_code = {prescaler_mode_reg[`CCPR_PRESC_A_HI - 4],
                         prescaler_mode_reg[`CCPR_PRESC_A_LO - 4]};
    wire [1:0] b_code = {prescaler_mode_reg[`CCPR_PRESC_B_HI - 4],
                         prescaler_mode_reg[`CCPR_PRESC_B_LO - 4]};

    // low mode bit has no effect on counting
    ccpr_pkg::ccpr_mode_t mode;
    assign mode = (mode_sel == 2'b00) ? ccpr_pkg::CCPR_STOP :
                  (mode_sel == 2'b01) ? ccpr_pkg::CCPR_FREE :
                  (mode_sel == 2'b10) ? ccpr_pkg::CCPR_CLR_TRIG :
                  ccpr_pkg::CCPR_CLR_MATCH;
    wire running = (mode != ccpr_pkg::CCPR_STOP);

    // valid edges; code 10 is left to software to avoid
    wire a_valid = ccpr_pkg::edge_hit(a_code, rise_a, fall_a);
    wire b_valid = ccpr_pkg::edge_hit(b_code, rise_b, fall_b);
    // pin a feeding register a runs in reverse phase, both = none
    wire a_rev = (a_code != `CCPR_EDGE_BOTH) &
                 ccpr_pkg::edge_hit(a_code, fall_a, rise_a);
    wire a_trig = a_src_pin_a ? a_rev : b_valid;

    // stopped timer ignores triggers; a trigger in the stop cycle
    // is dropped, which the undefined outcome allows
    wire cap_a = running & a_cap_mode & a_trig;
    wire cap_b = running & b_cap_mode & a_valid;

    wire [15:0] cc_a_val = cc_a_if.value;
    wire [15:0] cc_b_val = cc_b_if.value;
    wire hit_a_raw = ccpr_pkg::cc_match(count_reg, cc_a_val, wrapped_reg);
    wire hit_b_raw = ccpr_pkg::cc_match(count_reg, cc_b_val, wrapped_reg);
    wire cmp_a = running & ~a_cap_mode & hit_a_raw;
    wire cmp_b = running & ~b_cap_mode & hit_b_raw;
    wire [15:0] count_inc = 16'(count_reg + 16'h0001);
    // clear-on-match needs plain equality; zero compare is software's
    wire clr_match = (count_reg == cc_a_val);

    // counter keeps going past a compare set below it
    always_comb begin
        count_next = count_inc;
        unique case (mode)
            ccpr_pkg::CCPR_STOP: count_next = 16'h0000;
            ccpr_pkg::CCPR_FREE: count_next = count_inc;
            ccpr_pkg::CCPR_CLR_TRIG: begin
                count_next = a_valid ? 16'h0000 : count_inc;
            end
            ccpr_pkg::CCPR_CLR_MATCH: begin
                count_next = clr_match ? 16'h0000 : count_inc;
            end
        endcase
    end

    wire ovf_set = running & (count_reg == 16'hFFFF) &
                   (count_next == 16'h0000);
    assign wrapped_next = !running ? 1'b0 :
                          ovf_set ? 1'b1 :
                          (count_next == 16'h0000) ? 1'b0 : wrapped_reg;

    // overflow set wins over a clearing write
    assign timer_mode_next =
        (wr_fire & hit_mode) ?
            {pwdata_i[`CCPR_MODE_HI:`CCPR_MODE_LO],
             pwdata_i[`CCPR_MODE_OVF] | ovf_set} :
            {timer_mode_reg[3:1], timer_mode_reg[0] | ovf_set};

    // register links; writes are 16-bit, upper data ignored
    assign cc_a_if.count = count_reg;
    assign cc_a_if.wr_en = wr_fire & hit_cc_a;
    assign cc_a_if.wr_data = pwdata_i[15:0];
    assign cc_a_if.cap_en = cap_a;
    assign cc_b_if.count = count_reg;
    assign cc_b_if.wr_en = wr_fire & hit_cc_b;
    assign cc_b_if.wr_data = pwdata_i[15:0];
    assign cc_b_if.cap_en = cap_b;

    // read data is sampled in setup; a capture in the same window
    // may leave it stale, which is accepted
    wire [31:0] rd_data =
        hit_count ? {16'h0000, count_reg} :
        hit_cc_a ? {16'h0000, cc_a_val} :
        hit_cc_b ? {16'h0000, cc_b_val} :
        hit_mode ? {28'h0000000, timer_mode_reg} :
        hit_ctrl ? {29'h00000000, cc_control_reg} :
        hit_presc ? {24'h000000, prescaler_mode_reg, 4'h0} : 32'h00000000;

    // one wait-free access cycle after setup
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~hit_any;
            prdata_reg <= setup ? rd_data : prdata_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_mode_reg <= 4'(`CCPR_BYTE_RST);
            cc_control_reg <= 3'(`CCPR_BYTE_RST);
            prescaler_mode_reg <= 4'(`CCPR_BYTE_RST >> 4);
        end else begin
            timer_mode_reg <= timer_mode_next;
            if (wr_fire & hit_ctrl) begin
                cc_control_reg <= pwdata_i[2:0];
            end
            if (wr_fire & hit_presc) begin
                prescaler_mode_reg <= pwdata_i[7:4];
            end
        end
    end

    // capture samples count this cycle; pulse follows on next edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= 16'h0000;
            wrapped_reg <= 1'b0;
            irq_a_reg <= 1'b0;
            irq_b_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            wrapped_reg <= wrapped_next;
            irq_a_reg <= cmp_a | cap_a;
            irq_b_reg <= cmp_b | cap_b;
        end
    end

    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign match_irq_a_o = irq_a_reg;
    assign match_irq_b_o = irq_b_reg;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_stop_clears;
        (mode == ccpr_pkg::CCPR_STOP) |=> (count_reg == 16'h0000);
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("count not zero after stop");

    property p_free_inc;
        (mode == ccpr_pkg::CCPR_FREE) && (count_reg < cc_a_val)
            |=> (count_reg == $past(count_reg) + 16'h0001);
    endproperty
    a_free_inc: assert property (p_free_inc)
        else $error("count did not step by one");

    property p_clr_match;
        (mode == ccpr_pkg::CCPR_CLR_MATCH) && (count_reg == cc_a_val)
            |=> (count_reg == 16'h0000);
    endproperty
    a_clr_match: assert property (p_clr_match)
        else $error("count not cleared on match");

    property p_cmp_a;
        running && !a_cap_mode && (count_reg == cc_a_val) &&
            (cc_a_val != 16'h0000) |=> match_irq_a_o;
    endproperty
    a_cmp_a: assert property (p_cmp_a)
        else $error("missing compare interrupt a");

    property p_cmp_b;
        running && !b_cap_mode && (count_reg == cc_b_val) &&
            (cc_b_val != 16'h0000) |=> match_irq_b_o;
    endproperty
    a_cmp_b: assert property (p_cmp_b)
        else $error("missing compare interrupt b");

    property p_zero_wrap;
        (mode == ccpr_pkg::CCPR_FREE) && !a_cap_mode && !wr_fire &&
            (cc_a_val == 16'h0000) && (count_reg == 16'hFFFF)
            |=> ##1 match_irq_a_o;
    endproperty
    a_zero_wrap: assert property (p_zero_wrap)
        else $error("zero compare missed after wrap");

    property p_cap_a_pin_b;
        running && a_cap_mode && !a_src_pin_a && b_valid
            |=> (cc_a_val == $past(count_reg)) && match_irq_a_o;
    endproperty
    a_cap_a_pin_b: assert property (p_cap_a_pin_b)
        else $error("register a missed pin b capture");

    property p_cap_a_both;
        running && a_cap_mode && a_src_pin_a && !cc_a_if.wr_en &&
            (a_code == `CCPR_EDGE_BOTH) |=> $stable(cc_a_val);
    endproperty
    a_cap_a_both: assert property (p_cap_a_both)
        else $error("register a captured on both-edge code");

    property p_cap_b;
        running && b_cap_mode && a_valid
            |=> (cc_b_val == $past(count_reg)) && match_irq_b_o;
    endproperty
    a_cap_b: assert property (p_cap_b)
        else $error("register b missed pin a capture");

    property p_cmp_no_cap;
        !b_cap_mode && !cc_b_if.wr_en && a_valid |=> $stable(cc_b_val);
    endproperty
    a_cmp_no_cap: assert property (p_cmp_no_cap)
        else $error("compare register b captured");

    property p_edge_field;
        wr_fire && hit_presc |=> (a_code == $past(pwdata_i[5:4])) &&
            (b_code == $past(pwdata_i[7:6]));
    endproperty
    a_edge_field: assert property (p_edge_field)
        else $error("edge code field not stored");

    property p_apb_ready;
        setup |=> pready_o ##1 !pready_o;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("apb ready not one cycle after setup");

    c_cap_a: cover property (cap_a ##1 match_irq_a_o);
    c_cmp_b: cover property (cmp_b ##1 match_irq_b_o);
    c_ovf: cover property (ovf_set ##1 timer_mode_reg[0]);
    c_clr_trig: cover property
        ((mode == ccpr_pkg::CCPR_CLR_TRIG) && a_valid);
endmodule : ccpr_top

// ==== rtl/ccpr_params.svh ====
// register indices, field positions, reset values and edge codes of the
// capture/compare pair; included by the package and the register file
`ifndef CCPR_PARAMS_SVH
`define CCPR_PARAMS_SVH

// register indices; the byte address on the bus is four times the index
`define CCPR_IDX_COUNT 16'hFF12
`define CCPR_IDX_CC_A 16'hFF14
`define CCPR_IDX_CC_B 16'hFF16
`define CCPR_IDX_MODE 16'hFF60
`define CCPR_IDX_CTRL 16'hFF62
`define CCPR_IDX_PRESC 16'hFF64

// timer_mode_reg fields
`define CCPR_MODE_OVF 0
`define CCPR_MODE_LO 1
`define CCPR_MODE_MID 2
`define CCPR_MODE_HI 3

// cc_control_reg fields
`define CCPR_CTRL_A_CAP 0
`define CCPR_CTRL_A_SRC 1
`define CCPR_CTRL_B_CAP 2

// prescaler_mode_reg fields
`define CCPR_PRESC_A_LO 4
`define CCPR_PRESC_A_HI 5
`define CCPR_PRESC_B_LO 6
`define CCPR_PRESC_B_HI 7

// reset values
`define CCPR_CC_RST 16'h0000
`define CCPR_BYTE_RST 8'h00

// edge codes
`define CCPR_EDGE_FALL 2'b00
`define CCPR_EDGE_RISE 2'b01
`define CCPR_EDGE_BOTH 2'b11

`endif

// ==== rtl/ccpr_pkg.sv ====
// types and shared decode functions of the capture/compare pair
// assumes the params header sits on the include path
`include "ccpr_params.svh"

package ccpr_pkg;

    typedef enum logic [3:0] {
        CCPR_STOP = 4'b0001,
        CCPR_FREE = 4'b0010,
        CCPR_CLR_TRIG = 4'b0100,
        CCPR_CLR_MATCH = 4'b1000
    } ccpr_mode_t;

    // valid edge for a given code; the prohibited code 10 never fires
    function automatic logic edge_hit(input logic [1:0] code,
                                      input logic rise,
                                      input logic fall);
        logic hit;
        hit = 1'b0;
        case (code)
            `CCPR_EDGE_FALL: hit = fall;
            `CCPR_EDGE_RISE: hit = rise;
            `CCPR_EDGE_BOTH: hit = rise | fall;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // a zero compare value only matches once the count has wrapped
    function automatic logic cc_match(input logic [15:0] count,
                                      input logic [15:0] value,
                                      input logic wrapped);
        return (count == value) && ((value != 16'h0000) || wrapped);
    endfunction : cc_match

endpackage : ccpr_pkg

// ==== rtl/ccpr_cc_if.sv ====
// link between the register file and one capture/compare register
// assumes one instance per register, all on clk_sys_i
`timescale 1ns/1ps

interface ccpr_cc_if;
    logic [15:0] count;
    logic wr_en;
    logic [15:0] wr_data;
    logic cap_en;
    logic [15:0] value;

    modport ctrl (output count, output wr_en, output wr_data,
                  output cap_en, input value);
    modport unit (input count, input wr_en, input wr_data,
                  input cap_en, output value);
endinterface : ccpr_cc_if

// ==== rtl/ccpr_edge_det.sv ====
// rising and falling edge pulses of one trigger pin
// assumes the pin is already synchronous to clk_sys_i
`timescale 1ns/1ps

module ccpr_edge_det (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // pin and pulses
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);
    logic prev_reg;

    // a pin high out of reset reads as one rising edge
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= pin_i;
        end
    end

    assign rise_o = pin_i & ~prev_reg;
    assign fall_o = ~pin_i & prev_reg;
endmodule : ccpr_edge_det

// ==== rtl/ccpr_cc_reg.sv ====
// one 16-bit capture/compare register
// assumes the register file decides when to capture and when to write
`timescale 1ns/1ps
`include "ccpr_params.svh"

module ccpr_cc_reg (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // register link
    ccpr_cc_if.unit cc
);
    logic [15:0] value_reg;
    logic [15:0] value_next;

    // a capture beats a software write in the same cycle
    assign value_next = cc.cap_en ? cc.count :
                        cc.wr_en ? cc.wr_data : value_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_reg <= `CCPR_CC_RST;
        end else begin
            value_reg <= value_next;
        end
    end

    assign cc.value = value_reg;
endmodule : ccpr_cc_reg

// ==== dv/ccpr_trig_src.sv ====
// external signal source that drives both trigger pins of the pair
// assumes a bench that calls drive() and reads stamp_o afterwards
`timescale 1ns/1ps

module ccpr_trig_src (
    // clock
    input wire logic clk_sys_i,
    // trigger pins toward the block
    output logic trig_in_a_o,
    output logic trig_in_b_o,
    // cycle of the last level change
    output int stamp_o
);
    int cyc;

    initial begin
        trig_in_a_o = 1'b0;
        trig_in_b_o = 1'b0;
        stamp_o = 0;
        cyc = 0;
    end

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
    end

    // pin b is only ever an input here, nothing drives it back
    // callers keep every level for well over two clocks
    task automatic drive(input logic sel_a, input logic lvl);
        @(posedge clk_sys_i);
        if (sel_a) begin
            trig_in_a_o <= lvl;
        end else begin
            trig_in_b_o <= lvl;
        end
        stamp_o = cyc;
    endtask : drive
endmodule : ccpr_trig_src

// ==== dv/tb_timer_capture_compare_pair.sv ====
// self-checking bench of the capture/compare pair over apb
// assumes the design sources and ccpr_params.svh on the include path
`timescale 1ns/1ps
`include "ccpr_params.svh"

module tb_timer_capture_compare_pair;
    localparam logic [31:0] A_CNT = {14'h0000, `CCPR_IDX_COUNT, 2'b00};
    localparam logic [31:0] A_CCA = {14'h0000, `CCPR_IDX_CC_A, 2'b00};
    localparam logic [31:0] A_CCB = {14'h0000, `CCPR_IDX_CC_B, 2'b00};
    localparam logic [31:0] A_MODE = {14'h0000, `CCPR_IDX_MODE, 2'b00};
    localparam logic [31:0] A_CTRL = {14'h0000, `CCPR_IDX_CTRL, 2'b00};
    localparam logic [31:0] A_PRE = {14'h0000, `CCPR_IDX_PRESC, 2'b00};
    localparam logic [33:0] SKIP = 34'h200000000;
    // never code 10 on either pin: prohibited
    localparam logic [2:0] T_CTRL [9] = '{3'h1, 3'h1, 3'h1, 3'h3, 3'h3,
                                          3'h3, 3'h4, 3'h4, 3'h4};
    localparam logic [7:0] T_PRE [9] = '{8'h00, 8'h40, 8'hC0, 8'h10, 8'h00,
                                         8'h30, 8'h00, 8'h10, 8'h30};
    localparam int T_R [9] = '{0, 1, 1, 0, 1, 0, 0, 1, 1};
    localparam int T_F [9] = '{1, 1, 2, 1, 1, 0, 1, 1, 2};

    logic clk_sys_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rdata, v1, v2;
    logic trig_a, trig_b, irq_a, irq_b, sa;
    logic [33:0] exp_q [$];
    logic [33:0] e;
    logic [15:0] dv;
    int failures = 0, check_count = 0, cyc = 0, n_a = 0, n_b = 0;
    int t_a = 0, t_b = 0, stamp;
    int seed, i, ca, cb, tr, tf, t1, t2, t3;

    ccpr_top dut (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .trig_in_a_i(trig_a), .trig_in_b_i(trig_b),
        .match_irq_a_o(irq_a), .match_irq_b_o(irq_b)
    );

    ccpr_trig_src src (
        .clk_sys_i(clk_sys_i), .trig_in_a_o(trig_a), .trig_in_b_o(trig_b),
        .stamp_o(stamp)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [32:0] seen,
                       input logic [32:0] expv);
        check_count++;
        if (seen !== expv) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, expv, seen);
        end
    endtask : chk

    // one apb transfer; a read leaves its expected answer in the queue
    task automatic apb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, input logic [33:0] ex);
        int n;
        if (!wr) begin
            exp_q.push_back(ex);
        end
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        n = 0;
        @(posedge clk_sys_i);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk_sys_i);
            n++;
        end
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            failures++;
            $display("mismatch pready expected 1 seen timeout");
            final_report();
        end
    endtask : apb

    // bounded wait for the next pulse of one interrupt
    task automatic wait_irq(input logic sel_a, output int t);
        int base, n;
        base = sel_a ? n_a : n_b;
        n = 0;
        while ((sel_a ? n_a : n_b) == base && n < 400) begin
            @(posedge clk_sys_i);
            n++;
        end
        t = sel_a ? t_a : t_b;
        if (n == 400) begin
            failures++;
            $display("mismatch irq expected pulse seen none");
            final_report();
        end
    endtask : wait_irq

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (irq_a === 1'b1) begin
            n_a <= n_a + 1;
            t_a <= cyc;
        end
        if (irq_b === 1'b1) begin
            n_b <= n_b + 1;
            t_b <= cyc;
        end
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
            pwrite === 1'b0) begin
            e = exp_q.pop_front();
            if (e[33] === 1'b0) begin
                chk("read", {pslverr, prdata}, e[32:0]);
            end
        end
    end

    initial begin
        repeat (90000) @(posedge clk_sys_i);
        failures++;
        $display("mismatch run expected end seen timeout");
        final_report();
    end

    initial begin
        {rst_n_i, psel, penable, pwrite} = 4'h0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        seed = 32'h9C082F26;
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        apb(1'b0, A_CCA, 32'h0, 34'h0);
        apb(1'b0, A_CCB, 32'h0, 34'h0);
        apb(1'b0, A_MODE, 32'h0, 34'h0);
        apb(1'b0, A_CTRL, 32'h0, 34'h0);
        apb(1'b0, A_PRE, 32'h0, 34'h0);
        apb(1'b0, 32'h00000100, 32'h0, 34'h100000000);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            v1 = $random(seed);
            apb(1'b1, A_CCA, {16'h0000, v1[15:0]}, 34'h0);
            apb(1'b1, A_CCB, {16'h0000, v1[31:16]}, 34'h0);
            apb(1'b0, A_CCA, 32'h0, {18'h0, v1[15:0]});
            apb(1'b0, A_CCB, 32'h0, {18'h0, v1[31:16]});
        end
        apb(1'b1, A_CNT, 32'h00001234, 34'h0);
        apb(1'b0, A_CNT, 32'h0, 34'h0);
        apb(1'b1, A_MODE, 32'h00000004, 34'h0);
        apb(1'b0, A_MODE, 32'h0, 34'h4);
        apb(1'b1, A_MODE, 32'h0, 34'h0);
        apb(1'b0, A_CNT, 32'h0, 34'h0);
        $display("test registers done");
        apb(1'b1, A_CCA, 32'h00000030, 34'h0);
        apb(1'b1, A_CCB, 32'h00000020, 34'h0);
        ca = n_a;
        apb(1'b1, A_MODE, 32'h00000004, 34'h0);
        wait_irq(1'b0, t1);
        wait_irq(1'b1, t2);
        chk("match gap", 33'(t2 - t1), 33'h10);
        repeat (4) @(posedge clk_sys_i);
        chk("irq a pulses", 33'(n_a - ca), 33'h1);
        // a compare value below the count must wait for the wrap
        apb(1'b1, A_CCB, 32'h00000010, 34'h0);
        cb = n_b;
        repeat (200) @(posedge clk_sys_i);
        chk("irq b early", 33'(n_b - cb), 33'h0);
        apb(1'b1, A_MODE, 32'h0, 34'h0);
        apb(1'b1, A_CCA, 32'h00000010, 34'h0);
        apb(1'b1, A_MODE, 32'h0000000C, 34'h0);
        wait_irq(1'b1, t1);
        wait_irq(1'b1, t2);
        wait_irq(1'b1, t3);
        chk("clear period", 33'(t2 - t1), 33'h11);
        chk("clear period", 33'(t3 - t2), 33'h11);
        $display("test compare done");
        for (i = 0; i < 9; i++) begin
            apb(1'b1, A_MODE, 32'h0, 34'h0);
            apb(1'b1, A_CTRL, {29'h0, T_CTRL[i]}, 34'h0);
            apb(1'b1, A_PRE, {24'h0, T_PRE[i]}, 34'h0);
            apb(1'b1, A_MODE, 32'h00000004, 34'h0);
            sa = T_CTRL[i][1] | T_CTRL[i][2];
            ca = n_a;
            cb = n_b;
            src.drive(sa, 1'b1);
            tr = stamp;
            repeat (6) @(posedge clk_sys_i);
            chk("rise", 33'(T_CTRL[i][2] ? n_b - cb : n_a - ca),
                33'(T_R[i]));
            apb(1'b0, T_CTRL[i][2] ? A_CCB : A_CCA, 32'h0, SKIP);
            v1 = rdata;
            src.drive(sa, 1'b0);
            tf = stamp;
            repeat (6) @(posedge clk_sys_i);
            chk("fall", 33'(T_CTRL[i][2] ? n_b - cb : n_a - ca),
                33'(T_F[i]));
            apb(1'b0, T_CTRL[i][2] ? A_CCB : A_CCA, 32'h0, SKIP);
            v2 = rdata;
            dv = v2[15:0] - v1[15:0];
            if (T_F[i] == 2) begin
                chk("capture gap", {17'h0, dv}, 33'(tf - tr));
            end
        end
        $display("test capture done");
        // clear on a pin a edge, then compare b restarts from zero
        apb(1'b1, A_MODE, 32'h0, 34'h0);
        apb(1'b1, A_CTRL, 32'h0, 34'h0);
        apb(1'b1, A_CCA, 32'h0, 34'h0);
        apb(1'b1, A_CCB, 32'h00000010, 34'h0);
        apb(1'b1, A_MODE, 32'h00000008, 34'h0);
        src.drive(1'b1, 1'b1);
        tr = stamp;
        wait_irq(1'b0, t1);
        chk("clear on edge", 33'(t1 - tr), 33'h13);
        src.drive(1'b1, 1'b0);
        // zero compare only fires after a full wrap of the count
        apb(1'b1, A_MODE, 32'h0, 34'h0);
        ca = n_a;
        apb(1'b1, A_MODE, 32'h00000004, 34'h0);
        repeat (65500) @(posedge clk_sys_i);
        chk("zero early", 33'(n_a - ca), 33'h0);
        wait_irq(1'b1, t1);
        apb(1'b0, A_MODE, 32'h0, 34'h5);
        $display("test wrap done");
        final_report();
    end
endmodule : tb_timer_capture_compare_pair
